//--- hdl/spl_pkg.sv
// Package: constants, types and image layout for the serial preload loader
//
// Function
// - Header bits 7:6 must be 10b, else abort
// - Bytes 04h-06h, 0Bh-0Ch load primary class, grant, latency
// - Bytes 07h-0Ah load subsystem vendor and subsystem IDs
// - Bytes 0Dh-11h load secondary class, grant, latency
// - Bytes 12h-15h load downstream memory window 0
// - Bytes 16h-19h load downstream window 1, skip 5:4
// - Bytes 1Ah-1Dh load downstream memory window 2
// - Bytes 1Eh-21h load window 3 lower half
// - Bytes 22h-25h load window 3 upper half
// - Byte 26h loads expansion ROM enable and size
// - Byte 27h loads expansion ROM bits 23:16
// - Bytes 28h-2Ah load upstream window 0 bits 23:0, skip 5:4
// - Status bit shows preload was carried out
package spl_pkg;

   // Image layout
   localparam logic [7:0]  HDR_OFS   = 8'h00;
   localparam logic [1:0]  HDR_KEY   = 2'h2;
   localparam int unsigned HDR_HI    = 7;
   localparam int unsigned HDR_LO    = 6;
   localparam logic [7:0]  LAST_OFS  = 8'h2a;
   localparam logic [7:0]  EXP_OFS_A = 8'h26;
   localparam logic [7:0]  EXP_OFS_B = 8'h27;
   localparam int unsigned EXP_EN    = 24;
   localparam logic [31:0] EXP_RST   = 32'h00000000;

   // Byte-aligned windows: base offset, loaded-bit mask, reset value
   localparam int unsigned NWIN = 11;
   localparam logic [7:0] WIN_BASE [NWIN] = '{
      8'h04, 8'h07, 8'h0b, 8'h0d, 8'h10, 8'h12,
      8'h16, 8'h1a, 8'h1e, 8'h22, 8'h28};
   // Masked-out bits never load, so stray ones in the image are harmless
   localparam logic [31:0] WIN_MASK [NWIN] = '{
      32'h00ffffff, 32'hffffffff, 32'h0000ffff, 32'h00ffffff,
      32'h0000ffff, 32'hfffff00e, 32'hffffffcf, 32'hfffff00e,
      32'hfffff00e, 32'hffffffff, 32'h00ffffcf};
   localparam logic [31:0] WIN_RST [NWIN] = '{default: 32'h00000000};

   // APB register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_WIN0 = 12'h008;
   localparam logic [11:0] ADDR_EXP  = 12'h034;
   localparam int unsigned CTRL_RESTART = 0;
   localparam int unsigned CTRL_HOLD    = 1;
   localparam logic        HOLD_RST     = 1'b0;
   localparam int unsigned STAT_DONE = 0;
   localparam int unsigned STAT_BUSY = 1;
   localparam int unsigned STAT_BAD  = 2;
   localparam int unsigned STAT_OFS  = 8;

   typedef enum logic [1:0] {
      SPL_HDR, SPL_LOAD, SPL_DONE, SPL_FAIL
   } spl_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } spl_rom_t;

   typedef struct packed {
      logic [7:0]  pri_progif;
      logic [7:0]  pri_subclass;
      logic [7:0]  pri_class;
      logic [15:0] subsys_vid;
      logic [15:0] subsys_id;
      logic [7:0]  pri_min_gnt;
      logic [7:0]  pri_max_lat;
      logic [7:0]  sec_progif;
      logic [7:0]  sec_subclass;
      logic [7:0]  sec_class;
      logic [7:0]  sec_min_gnt;
      logic [7:0]  sec_max_lat;
      logic [31:0] ds_mem0;
      logic [31:0] ds_io1;
      logic [31:0] ds_mem2;
      logic [31:0] ds_mem3_lo;
      logic [31:0] ds_mem3_hi;
      logic [31:0] exp_rom;
      logic [31:0] us_io0;
   } spl_cfg_t;

endpackage : spl_pkg

//--- hdl/spl_win_load.sv
// Module: one 32-bit field loaded byte by byte from the image stream
`timescale 1ns/1ns
`default_nettype none
module spl_win_load #(
   parameter logic [7:0]  BASE = 8'h00,
   parameter logic [31:0] MASK = 32'hffffffff,
   parameter logic [31:0] RST  = 32'h00000000
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        clr,
   input  wire logic        take,
   input  wire logic [7:0]  ofs,
   input  wire logic [7:0]  data,
   output logic      [31:0] q_q
);

   logic [7:0]  diff;
   logic        hit;
   logic [31:0] lane_m;

   always_comb begin
      diff   = ofs - BASE;
      hit    = take && (diff < 8'h04);
      // Lane mask keeps unloaded bits at their reset value
      lane_m = MASK & (32'h000000ff << {diff[1:0], 3'h0});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= RST;
      end else if (ce) begin
         if (clr) begin
            q_q <= RST;
         end else if (hit) begin
            q_q <= (q_q & ~lane_m) | ({4{data}} & lane_m);
         end
      end
   end

endmodule : spl_win_load
`default_nettype wire

//--- hdl/spl_preload_top.sv
// Module: serial ROM preload loader with APB status and field readback
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module spl_preload_top #(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire spl_pkg::spl_rom_t rom_in,
   output logic                   rom_rd_ready,
   output logic      [7:0]        rom_offset,
   output logic                   rom_stop,
   output spl_pkg::spl_cfg_t      cfg,
   output logic                   preload_valid
);

   spl_pkg::spl_state_t state_q;
   logic [7:0]          ofs_q;
   logic                done_q;
   logic                bad_q;
   logic                hold_q;
   logic [31:0]         exp_q;
   logic [31:0]         win_q [spl_pkg::NWIN];
   logic                take;
   logic                load_take;
   logic                restart;
   logic                acc_done;
   logic                primed_q;
   logic [31:0]         prdata_q;
   logic                err_q;
   logic [31:0]         rd_mux;
   logic                rd_hit;
   logic                wr_ok;
   logic [11:0]         addr;

   assign addr = 12'(paddr);

   // ROM byte stream handshake
   always_comb begin
      rom_rd_ready = ((state_q == spl_pkg::SPL_HDR) ||
                      (state_q == spl_pkg::SPL_LOAD)) && !hold_q;
      take         = ce && rom_in.valid && rom_rd_ready;
      load_take    = take && (state_q == spl_pkg::SPL_LOAD);
   end

   // Terminated on a bad header and once our last byte is in
   assign rom_stop      = (state_q == spl_pkg::SPL_DONE) ||
                          (state_q == spl_pkg::SPL_FAIL);
   assign rom_offset    = ofs_q;
   assign preload_valid = done_q;

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= spl_pkg::SPL_HDR;
         ofs_q   <= spl_pkg::HDR_OFS;
      end else if (ce) begin
         if (restart) begin
            state_q <= spl_pkg::SPL_HDR;
            ofs_q   <= spl_pkg::HDR_OFS;
         end else if (take) begin
            unique case (state_q)
               spl_pkg::SPL_HDR: begin
                  // Reserved low bits are not checked, only the key
                  if (rom_in.data[spl_pkg::HDR_HI:spl_pkg::HDR_LO] ==
                      spl_pkg::HDR_KEY) begin
                     state_q <= spl_pkg::SPL_LOAD;
                     ofs_q   <= ofs_q + 8'h01;
                  end else begin
                     state_q <= spl_pkg::SPL_FAIL;
                  end
               end
               spl_pkg::SPL_LOAD: begin
                  if (ofs_q == spl_pkg::LAST_OFS) begin
                     state_q <= spl_pkg::SPL_DONE;
                  end else begin
                     ofs_q <= ofs_q + 8'h01;
                  end
               end
               spl_pkg::SPL_DONE: begin
               end
               spl_pkg::SPL_FAIL: begin
               end
            endcase
         end
      end
   end

   // Outcome flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         bad_q  <= 1'b0;
      end else if (ce) begin
         if (restart) begin
            done_q <= 1'b0;
            bad_q  <= 1'b0;
         end else if (load_take && ofs_q == spl_pkg::LAST_OFS) begin
            done_q <= 1'b1;
         end else if (take && state_q == spl_pkg::SPL_HDR &&
                      rom_in.data[spl_pkg::HDR_HI:spl_pkg::HDR_LO] !=
                      spl_pkg::HDR_KEY) begin
            bad_q <= 1'b1;
         end
      end
   end

   // Byte-aligned fields; a failed header never reaches load_take
   for (genvar i = 0; i < spl_pkg::NWIN; i++) begin : g_win
      spl_win_load #(
         .BASE (spl_pkg::WIN_BASE[i]),
         .MASK (spl_pkg::WIN_MASK[i]),
         .RST  (spl_pkg::WIN_RST[i])
      ) u_win (
         .pclk    (pclk),
         .presetn (presetn),
         .ce      (ce),
         .clr     (restart),
         .take    (load_take),
         .ofs     (ofs_q),
         .data    (rom_in.data),
         .q_q     (win_q[i])
      );
   end

   // Expansion ROM setup has a scattered bit layout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_q <= spl_pkg::EXP_RST;
      end else if (ce) begin
         if (restart) begin
            exp_q <= spl_pkg::EXP_RST;
         end else if (load_take && ofs_q == spl_pkg::EXP_OFS_A) begin
            exp_q[spl_pkg::EXP_EN] <= rom_in.data[0];
            exp_q[15:12]           <= rom_in.data[7:4];
         end else if (load_take && ofs_q == spl_pkg::EXP_OFS_B) begin
            exp_q[23:16] <= rom_in.data;
         end
      end
   end

   // Field map to the bridge configuration space
   always_comb begin
      cfg.pri_progif   = win_q[0][7:0];
      cfg.pri_subclass = win_q[0][15:8];
      cfg.pri_class    = win_q[0][23:16];
      cfg.subsys_vid   = win_q[1][15:0];
      cfg.subsys_id    = win_q[1][31:16];
      cfg.pri_min_gnt  = win_q[2][7:0];
      cfg.pri_max_lat  = win_q[2][15:8];
      cfg.sec_progif   = win_q[3][7:0];
      cfg.sec_subclass = win_q[3][15:8];
      cfg.sec_class    = win_q[3][23:16];
      cfg.sec_min_gnt  = win_q[4][7:0];
      cfg.sec_max_lat  = win_q[4][15:8];
      cfg.ds_mem0      = win_q[5];
      cfg.ds_io1       = win_q[6];
      cfg.ds_mem2      = win_q[7];
      cfg.ds_mem3_lo   = win_q[8];
      cfg.ds_mem3_hi   = win_q[9];
      cfg.exp_rom      = exp_q;
      cfg.us_io0       = win_q[10];
   end

   // APB slave: read data is captured one cycle early so it comes
   // from a flop; primed_q stops a completion on stale data
   assign acc_done = psel && penable && pready;
   assign pready   = ce && primed_q;
   assign prdata   = prdata_q;
   assign pslverr  = err_q && pready;
   assign wr_ok    = acc_done && pwrite && !err_q;
   assign restart  = wr_ok && addr == spl_pkg::ADDR_CTRL && pstrb[0] &&
                     pwdata[spl_pkg::CTRL_RESTART];

   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b0;
      if (addr == spl_pkg::ADDR_CTRL) begin
         rd_hit = 1'b1;
         rd_mux[spl_pkg::CTRL_HOLD] = hold_q;
      end else if (addr == spl_pkg::ADDR_STAT) begin
         rd_hit = 1'b1;
         rd_mux[spl_pkg::STAT_DONE] = done_q;
         rd_mux[spl_pkg::STAT_BUSY] = rom_rd_ready || hold_q;
         rd_mux[spl_pkg::STAT_BAD]  = bad_q;
         rd_mux[spl_pkg::STAT_OFS +: 8] = ofs_q;
      end else if (addr == spl_pkg::ADDR_EXP) begin
         rd_hit = 1'b1;
         rd_mux = exp_q;
      end else begin
         for (int i = 0; i < spl_pkg::NWIN; i++) begin
            if (addr == spl_pkg::ADDR_WIN0 + 12'(4 * i)) begin
               rd_hit = 1'b1;
               rd_mux = win_q[i];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primed_q <= 1'b0;
         prdata_q <= 32'h00000000;
         err_q    <= 1'b0;
      end else if (ce) begin
         if (acc_done) begin
            primed_q <= 1'b0;
         end else if (psel) begin
            primed_q <= 1'b1;
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            // Only the control word takes writes
            err_q    <= !rd_hit ||
                        (pwrite && addr != spl_pkg::ADDR_CTRL);
         end
      end
   end

   // Hold pauses the ROM stream without losing position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= spl_pkg::HOLD_RST;
      end else if (ce) begin
         if (wr_ok && addr == spl_pkg::ADDR_CTRL && pstrb[0]) begin
            hold_q <= pwdata[spl_pkg::CTRL_HOLD];
         end
      end
   end

endmodule : spl_preload_top
`default_nettype wire

//--- verification/spl_preload_chk.sv
// Checker: temporal rules on the preload loader ports
`timescale 1ns/1ns
`default_nettype none
module spl_preload_chk (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   input wire logic              psel,
   input wire spl_pkg::spl_rom_t rom_in,
   input wire logic              rom_rd_ready,
   input wire logic [7:0]        rom_offset,
   input wire logic              rom_stop,
   input wire spl_pkg::spl_cfg_t cfg,
   input wire logic              preload_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic       tk = rom_in.valid & rom_rd_ready & ce;
   wire logic [7:0] d  = rom_in.data;
   property p_hdr;
      tk && rom_offset == 8'h00 && d[7:6] != 2'h2 |=> rom_stop && !preload_valid;
   endproperty
   a_hdr: assert property (p_hdr) else $error("bad header not refused");
   property p_zero;
      rom_stop && !preload_valid |-> cfg == '0;
   endproperty
   a_zero: assert property (p_zero) else $error("fields loaded on abort");
   // Offset parks on the last byte and on a refused header
   property p_ofs;
      tk |=> rom_offset == (($past(rom_offset) == 8'h2a ||
         ($past(rom_offset) == 8'h00 && $past(d[7:6]) != 2'h2)) ?
         $past(rom_offset) : $past(rom_offset) + 8'h01);
   endproperty
   a_ofs: assert property (p_ofs) else $error("offset not advanced");
   property p_hold;
      !tk && !psel |=> $stable(rom_offset);
   endproperty
   a_hold: assert property (p_hold) else $error("offset moved idle");
   property p_pri;
      tk && rom_offset == 8'h04 |=> cfg.pri_progif == $past(d);
   endproperty
   a_pri: assert property (p_pri) else $error("progif wrong");
   property p_vid;
      tk && rom_offset == 8'h08 |=> cfg.subsys_vid[15:8] == $past(d);
   endproperty
   a_vid: assert property (p_vid) else $error("vendor high wrong");
   property p_sec;
      tk && rom_offset == 8'h11 |=> cfg.sec_max_lat == $past(d);
   endproperty
   a_sec: assert property (p_sec) else $error("latency wrong");
   property p_win;
      cfg.ds_mem0[11:4] == 0 && !cfg.ds_mem2[0] && cfg.ds_io1[5:4] == 0
         && cfg.ds_mem3_lo[11:4] == 0 && cfg.us_io0[5:4] == 0;
   endproperty
   a_win: assert property (p_win) else $error("unloaded bit set");
   property p_exp;
      tk && rom_offset == 8'h26 |=> cfg.exp_rom[24] == $past(d[0])
         && cfg.exp_rom[15:12] == $past(d[7:4]);
   endproperty
   a_exp: assert property (p_exp) else $error("rom setup wrong");
   property p_end;
      tk && rom_offset == 8'h2a |=> preload_valid && rom_stop
         && cfg.us_io0[23:16] == $past(d);
   endproperty
   a_end: assert property (p_end) else $error("load not closed");
endmodule : spl_preload_chk
bind spl_preload_top spl_preload_chk spl_preload_chk_i (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .rom_in(rom_in),
   .rom_rd_ready(rom_rd_ready), .rom_offset(rom_offset),
   .rom_stop(rom_stop), .cfg(cfg), .preload_valid(preload_valid));
`default_nettype wire

//--- verification/spl_rom_model.sv
// Partner: serial ROM streaming the preload image
`timescale 1ns/1ns
`default_nettype none
module spl_rom_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        gap,
   input  wire logic [7:0]  img [43],
   input  wire logic        rom_rd_ready,
   input  wire logic        rom_stop,
   output spl_pkg::spl_rom_t rom_out
);
   int unsigned ptr_q;
   wire logic [31:0] nxt = ptr_q + 32'(rom_out.valid);
   wire logic go = nxt < 43 && !gap;
   // Idle data toggles so a stale byte is never mistaken for a new one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q   <= 0;
         rom_out <= '0;
      end else if (rom_stop) begin
         rom_out <= '{valid: 1'b0, data: ~rom_out.data};
      end else if (!rom_out.valid || (rom_rd_ready && ce)) begin
         ptr_q         <= nxt;
         rom_out.valid <= go;
         rom_out.data  <= go ? img[nxt] : ~rom_out.data;
      end
   end
endmodule : spl_rom_model
`default_nettype wire

//--- verification/spl_preload_top_tb_top.sv
// Testbench: loader against an image model, a ROM partner and APB reads
`timescale 1ns/1ns
`default_nettype none
module spl_preload_top_tb_top;
   logic              pclk, presetn, ce, psel, penable, pwrite, gap, slow;
   logic              pready, pslverr, rom_rd_ready, rom_stop, preload_valid;
   logic              er, good;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [7:0]        rom_offset, ho;
   logic [7:0]        img [43];
   logic [7:0]        hdrs [5] = '{8'h80, 8'h80, 8'h00, 8'h40, 8'hc0};
   spl_pkg::spl_rom_t rom_in;
   spl_pkg::spl_cfg_t cfg, ex;
   int                seed = 56, n_fail = 0, compares = 0, cyc = 0, i, k;
   spl_preload_top spl_preload_top_i (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rom_in(rom_in),
      .rom_rd_ready(rom_rd_ready), .rom_offset(rom_offset),
      .rom_stop(rom_stop), .cfg(cfg), .preload_valid(preload_valid));
   spl_rom_model spl_rom_model_i (.pclk(pclk), .presetn(presetn), .ce(ce),
      .gap(gap), .img(img), .rom_rd_ready(rom_rd_ready),
      .rom_stop(rom_stop), .rom_out(rom_in));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      ce  <= ($random(seed) & 7) != 0;
      gap <= slow && ($random(seed) & 1);
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         conclude();
      end
   end
   function automatic logic [31:0] w4(int b);
      return {img[b+3], img[b+2], img[b+1], img[b]};
   endfunction : w4
   // Unloaded positions are masked, whatever the image holds there
   function automatic spl_pkg::spl_cfg_t model();
      return '{img[4], img[5], img[6], {img[8], img[7]}, {img[10], img[9]},
         img[11], img[12], img[13], img[14], img[15], img[16], img[17],
         w4(18) & 32'hfffff00e, w4(22) & 32'hffffffcf,
         w4(26) & 32'hfffff00e, w4(30) & 32'hfffff00e, w4(34),
         {7'h00, img[38][0], img[39], img[38][7:4], 12'h000},
         {8'h00, img[42], img[41], img[40] & 8'hcf}};
   endfunction : model
   task automatic check(input logic [335:0] s, input logic [335:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   // Leading edge keeps one idle cycle between calls
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic conclude();
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   initial begin
      {presetn, ce, psel, penable, pwrite, gap, slow} = 7'h20;
      paddr  = 12'h000;
      pwdata = 32'h00000000;
      for (i = 0; i < 5; i++) begin
         img[0] = hdrs[i];
         for (k = 1; k < 43; k++) img[k] = 8'($random(seed));
         if (i == 0) begin // Clean image; later runs carry stray ones
            for (k = 1; k < 4; k++) img[k] = 8'h00;
            for (k = 18; k < 34; k += 4) img[k] &= (k == 22) ? 8'hcf : 8'h0e;
            for (k = 19; k < 34; k += 4) img[k] &= (k == 23) ? 8'hff : 8'hf0;
            img[38] &= 8'hf1;
            img[40] &= 8'hcf;
         end
         good = hdrs[i][7:6] === 2'h2;
         slow = i == 0;
         @(posedge pclk);
         presetn <= 1'b0;
         repeat (4) @(posedge pclk);
         presetn <= 1'b1;
         if (i == 1) begin // Hold pauses the stream mid-image
            apb(1'b1, 12'h000, 32'h00000002);
            @(posedge pclk);
            ho = rom_offset;
            repeat (20) @(posedge pclk);
            check({rom_offset, rom_rd_ready}, {ho, 1'b0});
            apb(1'b0, 12'h004, 32'h0);
            check({er, rd[1], rd[15:8]}, {1'b0, 1'b1, ho});
            apb(1'b0, 12'h000, 32'h0);
            check({er, rd}, {1'b0, 32'h00000002});
            apb(1'b1, 12'h000, 32'h00000000);
         end
         for (k = 0; k < 600 && rom_stop !== 1'b1; k++) @(posedge pclk);
         repeat (2) @(posedge pclk);
         ex = good ? model() : '0;
         check(cfg, ex);
         check(preload_valid, good);
         check(rom_offset, good ? 8'h2a : 8'h00);
         check({rom_stop, rom_rd_ready}, 2'b10);
         apb(1'b0, 12'h004, 32'h0);
         check({er, rd[2], rd[0]}, {1'b0, !good, good});
         apb(1'b0, 12'h008, 32'h0);
         check(rd, {8'h00, ex.pri_class, ex.pri_subclass, ex.pri_progif});
         if (i == 0) begin
            apb(1'b0, 12'h100, 32'h0);
            check(er, 1'b1);
            apb(1'b1, 12'h004, 32'hffffffff);
            check(er, 1'b1);
            // Restart clears every field and rewinds to offset zero
            apb(1'b1, 12'h000, 32'h00000001);
            @(posedge pclk);
            check(cfg, '0);
            check({er, preload_valid, rom_stop, rom_offset}, 11'h000);
         end
      end
      conclude();
   end
endmodule : spl_preload_top_tb_top
`default_nettype wire
